// ---- hw/rtc_divider.sv ----
// Purpose: Low-speed clock divider producing 32, 8, 4 and 1 Hz strobes.
// Assumes: tick is a one-cycle pulse per low-speed clock period.
// Notes:   clear restarts the chain so the first second is a full one.

`timescale 1ns/100ps
`default_nettype none

module rtc_divider
   import rtc_pkg::*;
#(
   parameter int DIV_W = TAP_1HZ
) (
   input  wire logic clk,
   input  wire logic rst,
   input  wire logic clear,
   input  wire logic tick,
   output logic      strobe_32hz,
   output logic      strobe_8hz,
   output logic      strobe_4hz,
   output logic      strobe_1hz
);

   logic [DIV_W-1:0] count_reg;

   // Divider counts only gated ticks; a run write of 1 restarts it
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         count_reg   <= '0;
         strobe_32hz <= 1'b0;
         strobe_8hz  <= 1'b0;
         strobe_4hz  <= 1'b0;
         strobe_1hz  <= 1'b0;
      end else begin
         count_reg   <= clear ? '0 : (tick ? count_reg + 1'b1 : count_reg);
         strobe_32hz <= ~clear & tick & (&count_reg[TAP_32HZ-1:0]);
         strobe_8hz  <= ~clear & tick & (&count_reg[TAP_8HZ-1:0]);
         strobe_4hz  <= ~clear & tick & (&count_reg[TAP_4HZ-1:0]);
         strobe_1hz  <= ~clear & tick & (&count_reg[DIV_W-1:0]);
      end
   end

endmodule : rtc_divider

`default_nettype wire

// ---- hw/rtc_pkg.sv ----
// Purpose: Shared constants and types for the real-time clock run control,
//          counting-mode selection and interrupt gating logic.
// Assumes: APB slave with 32-bit data; register indices are word indices.
// Notes:   Byte address of a register is four times its index.

package rtc_pkg;

   // Bus geometry
   localparam int unsigned ADDR_W = 20;
   localparam int unsigned DATA_W = 32;

   // Register indices and their byte addresses
   localparam logic [15:0] IDX_CTL  = 16'h56C0;
   localparam logic [15:0] IDX_IEN  = 16'h56C2;
   localparam logic [15:0] IDX_IFLG = 16'h56C4;
   localparam logic [15:0] IDX_MS   = 16'h56C6;
   localparam logic [15:0] IDX_H    = 16'h56C8;
   localparam logic [ADDR_W-1:0] ADDR_CTL  = {2'h0, IDX_CTL, 2'h0};
   localparam logic [ADDR_W-1:0] ADDR_IEN  = {2'h0, IDX_IEN, 2'h0};
   localparam logic [ADDR_W-1:0] ADDR_IFLG = {2'h0, IDX_IFLG, 2'h0};
   localparam logic [ADDR_W-1:0] ADDR_MS   = {2'h0, IDX_MS, 2'h0};
   localparam logic [ADDR_W-1:0] ADDR_H    = {2'h0, IDX_H, 2'h0};

   // Control register fields
   localparam int CTL_RUN_BIT  = 0;
   localparam int CTL_H24_BIT  = 4;
   localparam int CTL_BCD_BIT  = 5;
   localparam int CTL_STAT_BIT = 8;

   // Interrupt causes, bit positions in enable and flag registers
   localparam int NUM_IRQ = 10;
   localparam int EV_32HZ = 0;
   localparam int EV_8HZ  = 1;
   localparam int EV_4HZ  = 2;
   localparam int EV_1HZ  = 3;
   localparam int EV_10S  = 4;
   localparam int NUM_TEV = 6;
   localparam logic [NUM_IRQ-1:0] IEN_RESET  = 10'h000;
   localparam logic [NUM_IRQ-1:0] IFLG_RESET = 10'h000;

   // Counter register fields
   localparam int MS_SEC_LSB  = 0;
   localparam int MS_MIN_LSB  = 8;
   localparam int H_AMPM_BIT  = 7;

   // Low-speed clock divider taps, counter width is the 1 Hz tap
   localparam int unsigned LS_CLK_HZ = 32768;
   localparam int TAP_32HZ = 10;
   localparam int TAP_8HZ  = 12;
   localparam int TAP_4HZ  = 13;
   localparam int TAP_1HZ  = 15;

   // Time counter limits
   localparam logic [5:0] SEC_MAX   = 6'h3B;
   localparam logic [5:0] MIN_MAX   = 6'h3B;
   localparam logic [4:0] HOUR_MAX  = 5'h17;
   localparam logic [4:0] HOUR_NOON = 5'h0C;
   localparam logic [3:0] DIGIT_LAST = 4'h9;
   localparam logic [6:0] TEN        = 7'h0A;

   typedef struct packed {
      logic h24;
      logic bcd;
      logic run;
   } ctl_t;

   typedef struct packed {
      logic [4:0] hour;
      logic [5:0] min;
      logic [5:0] sec;
   } clock_time_t;

   localparam ctl_t        CTL_RESET  = '{h24: 1'b0, bcd: 1'b0, run: 1'b0};
   localparam clock_time_t TIME_RESET = '{hour: 5'h00, min: 6'h00,
                                          sec: 6'h00};

endpackage : rtc_pkg

// ---- hw/rtc_run_control.sv ----
// Purpose: Real-time clock run/stop control, binary/BCD and 12/24-hour
//          counting modes, and periodic interrupt gating, on an APB slave.
// Assumes: LS_CLK is the low-speed oscillator clock, sampled as an ordinary
//          input synchronous to REF_CLK (10 MHz, far faster than LS_CLK).
// Notes:   Zero-wait APB; read data is captured in the setup cycle.
//
// The implementer's own choice: the APB interface to the registers.

`timescale 1ns/100ps
`default_nettype none

// Overview of operation
// RQ1: Run status rises once counting really begins after run control is set.
// RQ2: Run status stays high after run control clears until counting halts.
// RQ3: Software stops, then polls status low, before loading counters.
// RQ4: Control bit 5 selects BCD when 1, binary when 0; resets binary.
// RQ5: Counters are read and written as binary or two-digit BCD values.
// RQ6: Control bit 4 selects 24-hour when 1, 12-hour when 0 at reset.
// RQ7: Hour counter range follows the currently selected hour mode.
// RQ8: Software should change hour mode only while stopped or when starting.
// RQ9: Control bit 0 runs when 1, stops when 0; resets to stopped.
// RQ10: Clock to the counters is gated through only while run control is 1.
// RQ11: Low-speed oscillator stays alive in sleep while run control is 1.
// RQ12: Every write of 1 to run control resets the low-speed divider.
// RQ13: Ten enable bits, bits 9 down to 0, day to 32 Hz, reset 0.
// RQ14: Enabled cause sets its flag each period and requests an interrupt.
// RQ15: A disabled cause never requests an interrupt.
// RQ16: Writing 1 to a flag clears it; writing 0 leaves it.
// RQ17: Ten flags in bits 9 down to 0 in enable order, reset 0.
// RQ18: Interrupt line is high while any flag and its enable are both 1.
module rtc_run_control
   import rtc_pkg::*;
(
   input  wire logic                REF_CLK,
   input  wire logic                RST,
   input  wire logic                PSEL,
   input  wire logic                PENABLE,
   input  wire logic                PWRITE,
   input  wire logic [ADDR_W-1:0]   PADDR,
   input  wire logic [DATA_W-1:0]   PWDATA,
   output logic      [DATA_W-1:0]   PRDATA,
   output logic                     PREADY,
   output logic                     PSLVERR,
   input  wire logic                LS_CLK,
   output logic                     IRQ,
   output logic                     RTC_CLK_GATE_EN,
   output logic                     LS_OSC_KEEP_ALIVE
);

   import rtc_pkg::*;

   ////////////////////////////////////////////////////////////////////////
   // Conversion helpers

   // Binary value below 80 to two-digit BCD
   // Counters never pass 59, so three tens bits do
   function automatic logic [6:0] to_bcd(input logic [6:0] v);
      logic [6:0] tens;
      logic [6:0] ones;
      tens = 7'(v / TEN);
      ones = 7'(v % TEN);
      return 7'({tens[2:0], ones[3:0]});
   endfunction : to_bcd

   // Two-digit BCD to binary
   function automatic logic [6:0] from_bcd(input logic [6:0] v);
      logic [6:0] tens;
      tens = {4'h0, v[6:4]};
      return 7'(tens * TEN + {3'h0, v[3:0]});
   endfunction : from_bcd

   ////////////////////////////////////////////////////////////////////////
   // State

   // Software-visible state
   ctl_t               ctl_reg;
   logic               run_status_reg;
   logic [NUM_IRQ-1:0] ien_reg;
   logic [NUM_IRQ-1:0] iflg_reg;

   // Bus answer
   logic [DATA_W-1:0]  prdata_reg;
   logic               pready_reg;
   logic               pslverr_reg;

   // Pins toward interrupt and clock logic
   logic               irq_reg;
   logic               gate_reg;
   logic               keep_alive_reg;

   // Low-speed clock history
   logic               ls_prev_reg;

   // Next values
   ctl_t               ctl_next;
   logic [NUM_IRQ-1:0] ien_next;
   logic [NUM_IRQ-1:0] iflg_next;

   ////////////////////////////////////////////////////////////////////////
   // APB decode

   // PREADY stays high, so every access ends at its first
   // edge and read data must be settled in the setup cycle
   wire logic setup_phase = PSEL & ~PENABLE;
   wire logic access      = PSEL & PENABLE & pready_reg;

   wire logic hit_ctl     = (PADDR == ADDR_CTL);
   wire logic hit_ien     = (PADDR == ADDR_IEN);
   wire logic hit_iflg    = (PADDR == ADDR_IFLG);
   wire logic hit_ms      = (PADDR == ADDR_MS);
   wire logic hit_h       = (PADDR == ADDR_H);
   wire logic hit_any     = hit_ctl | hit_ien | hit_iflg | hit_ms | hit_h;
   wire logic wr_access   = access & PWRITE;

   // Writes take effect only at the access edge
   wire logic wr_ctl  = wr_access & hit_ctl;
   wire logic wr_ien  = wr_access & hit_ien;
   wire logic wr_iflg = wr_access & hit_iflg;
   wire logic wr_ms   = wr_access & hit_ms;
   wire logic wr_h    = wr_access & hit_h;

   // A run write of 1 restarts the divider even if already running
   wire logic div_clear = wr_ctl & PWDATA[CTL_RUN_BIT];          // [RQ12]

   ////////////////////////////////////////////////////////////////////////
   // Low-speed clock gating

   // A stop written just after a tick waits a whole
   // low-speed period before status falls

   // Rising edge of the low-speed clock, one REF_CLK cycle wide
   wire logic ls_tick    = LS_CLK & ~ls_prev_reg;
   // Counting ticks exist only while run control is set
   wire logic count_tick = ls_tick & ctl_reg.run;                // [RQ10]

   logic strobe_32hz;
   logic strobe_8hz;
   logic strobe_4hz;
   logic strobe_1hz;

   rtc_divider #(
      .DIV_W (TAP_1HZ)
   ) u_divider (
      .clk         (REF_CLK),
      .rst         (RST),
      .clear       (div_clear),
      .tick        (count_tick),
      .strobe_32hz (strobe_32hz),
      .strobe_8hz  (strobe_8hz),
      .strobe_4hz  (strobe_4hz),
      .strobe_1hz  (strobe_1hz)
   );

   ////////////////////////////////////////////////////////////////////////
   // Time counters and register formats

   // Counter state is always held in binary
   clock_time_t        time_q;
   clock_time_t        load_val;
   logic [NUM_TEV-1:0] time_ev;

   // Write data in the selected representation, converted to binary
   wire logic [6:0] wr_sec_raw  = PWDATA[MS_SEC_LSB +: 7];
   wire logic [6:0] wr_min_raw  = PWDATA[MS_MIN_LSB +: 7];
   wire logic [6:0] wr_hour_raw = {1'b0, PWDATA[5:0]};

   wire logic [6:0] wr_sec  = ctl_reg.bcd ? from_bcd(wr_sec_raw)
                                          : wr_sec_raw;          // [RQ5]
   wire logic [6:0] wr_min  = ctl_reg.bcd ? from_bcd(wr_min_raw)
                                          : wr_min_raw;          // [RQ5]
   wire logic [6:0] wr_hour = ctl_reg.bcd ? from_bcd(wr_hour_raw)
                                          : wr_hour_raw;         // [RQ5]
   wire logic       wr_pm   = PWDATA[H_AMPM_BIT];

   // In 12-hour mode twelve means the top of the half; PM adds twelve
   wire logic [4:0] wr_h12   = (wr_hour[4:0] == HOUR_NOON) ? 5'h00
                                                             : wr_hour[4:0];
   wire logic [4:0] wr_h_bin = ctl_reg.h24 ? wr_hour[4:0]
                             : wr_h12 + (wr_pm ? HOUR_NOON : 5'h00); // [RQ7]

   assign load_val.sec  = wr_sec[5:0];
   assign load_val.min  = wr_min[5:0];
   assign load_val.hour = wr_h_bin;

   // Seconds advance only on gated 1 Hz strobes
   rtc_time_counter u_time (
      .clk      (REF_CLK),
      .rst      (RST),
      .sec_tick (strobe_1hz),
      .load_ms  (wr_ms),
      .load_h   (wr_h),
      .load_val (load_val),
      .time_q   (time_q),
      .ev_q     (time_ev)
   );

   // Read views: 12-hour shows 12,1..11 with a PM flag
   wire logic       is_pm     = (time_q.hour >= HOUR_NOON);
   wire logic [4:0] h_mod     = is_pm ? time_q.hour - HOUR_NOON : time_q.hour;
   wire logic [4:0] h_12      = (h_mod == 5'h00) ? HOUR_NOON : h_mod;
   wire logic [4:0] h_view    = ctl_reg.h24 ? time_q.hour : h_12; // [RQ7]

   wire logic [6:0] rd_sec    = ctl_reg.bcd ? to_bcd({1'b0, time_q.sec})
                                            : {1'b0, time_q.sec}; // [RQ5]
   wire logic [6:0] rd_min    = ctl_reg.bcd ? to_bcd({1'b0, time_q.min})
                                            : {1'b0, time_q.min}; // [RQ5]
   wire logic [6:0] rd_hour   = ctl_reg.bcd ? to_bcd({2'h0, h_view})
                                            : {2'h0, h_view};     // [RQ5]

   ////////////////////////////////////////////////////////////////////////
   // Control, enable and flag next values

   // Mode bits and run bit from a control write
   always_comb begin
      ctl_next = ctl_reg;
      if (wr_ctl) begin
         ctl_next.run = PWDATA[CTL_RUN_BIT];                     // [RQ9]
         ctl_next.bcd = PWDATA[CTL_BCD_BIT];                     // [RQ4]
         ctl_next.h24 = PWDATA[CTL_H24_BIT];                     // [RQ6]
      end
   end

   assign ien_next = wr_ien ? PWDATA[NUM_IRQ-1:0] : ien_reg;     // [RQ13]

   // Cause vector, day at the top, 32 Hz at the bottom
   wire logic [NUM_IRQ-1:0] cause = {time_ev, strobe_1hz, strobe_4hz,
                                     strobe_8hz, strobe_32hz};   // [RQ17]
   wire logic [NUM_IRQ-1:0] clr   = wr_iflg ? PWDATA[NUM_IRQ-1:0]
                                            : '0;                // [RQ16]

   // A cause in the same cycle as its clear wins over the clear
   assign iflg_next = (iflg_reg & ~clr) | cause;                 // [RQ14]

   // Zero-filled read views of each register
   wire logic [DATA_W-1:0] rd_ctl  = DATA_W'(
      ({31'h0, run_status_reg} << CTL_STAT_BIT) |
      ({31'h0, ctl_reg.bcd} << CTL_BCD_BIT) |
      ({31'h0, ctl_reg.h24} << CTL_H24_BIT) |
      ({31'h0, ctl_reg.run} << CTL_RUN_BIT));

   wire logic [DATA_W-1:0] rd_ien  = {22'h0, ien_reg};
   wire logic [DATA_W-1:0] rd_iflg = {22'h0, iflg_reg};
   wire logic [DATA_W-1:0] rd_ms   = {16'h0, 1'b0, rd_min, 1'b0, rd_sec};
   wire logic [DATA_W-1:0] rd_h    = {24'h0, is_pm, rd_hour};

   wire logic [DATA_W-1:0] rd_mux =
      hit_ctl  ? rd_ctl  :
      hit_ien  ? rd_ien  :
      hit_iflg ? rd_iflg :
      hit_ms   ? rd_ms   :
      hit_h    ? rd_h    : '0;

   ////////////////////////////////////////////////////////////////////////
   // Registers

   // Timing, in REF_CLK edges:
   //  control write to gate and keep-alive: 1
   //  LS_CLK rise seen to status change: 1
   //  strobe to flag and IRQ: 1
   //  write-1 clear to IRQ low: 1
   // Limitation: LS_CLK needs one cycle per level

   // Edge detect of the low-speed clock
   always_ff @(posedge REF_CLK or posedge RST) begin
      if (RST) begin
         ls_prev_reg <= 1'b0;
      end else begin
         ls_prev_reg <= LS_CLK;
      end
   end

   // Status follows run control only at a low-speed edge, i.e. when the
   // counters actually start or stop; this is what software must poll
   always_ff @(posedge REF_CLK or posedge RST) begin
      if (RST) begin
         run_status_reg <= 1'b0;
      end else if (ls_tick) begin
         run_status_reg <= ctl_reg.run;                          // [RQ1] [RQ2]
      end
   end

   // Software-visible control, enables and flags
   always_ff @(posedge REF_CLK or posedge RST) begin
      if (RST) begin
         ctl_reg  <= CTL_RESET;                                  // [RQ9]
         ien_reg  <= IEN_RESET;                                  // [RQ13]
         iflg_reg <= IFLG_RESET;                                 // [RQ17]
      end else begin
         ctl_reg  <= ctl_next;
         ien_reg  <= ien_next;
         iflg_reg <= iflg_next;
      end
   end

   // Request line; only enabled flags reach it
   always_ff @(posedge REF_CLK or posedge RST) begin
      if (RST) begin
         irq_reg <= 1'b0;
      end else begin
         irq_reg <= |(iflg_next & ien_next);                     // [RQ15] [RQ18]
      end
   end

   // Clock gate and oscillator keep-alive follow run control directly
   always_ff @(posedge REF_CLK or posedge RST) begin
      if (RST) begin
         gate_reg       <= 1'b0;
         keep_alive_reg <= 1'b0;
      end else begin
         gate_reg       <= ctl_next.run;                         // [RQ10]
         keep_alive_reg <= ctl_next.run;                         // [RQ11]
      end
   end

   // Bus answer; data and error are settled in the setup cycle so the
   // access phase can complete with no wait state
   always_ff @(posedge REF_CLK or posedge RST) begin
      if (RST) begin
         prdata_reg  <= '0;
         pready_reg  <= 1'b0;
         pslverr_reg <= 1'b0;
      end else begin
         pready_reg <= 1'b1;
         if (setup_phase) begin
            prdata_reg  <= PWRITE ? '0 : rd_mux;
            pslverr_reg <= ~hit_any;
         end
      end
   end

   // All outputs come straight from registers
   assign PRDATA            = prdata_reg;
   assign PREADY            = pready_reg;
   assign PSLVERR           = pslverr_reg;

   assign IRQ               = irq_reg;
   assign RTC_CLK_GATE_EN   = gate_reg;
   assign LS_OSC_KEEP_ALIVE = keep_alive_reg;

endmodule : rtc_run_control

`default_nettype wire

// ---- hw/rtc_time_counter.sv ----
// Purpose: Binary second, minute and hour counters with period events.
// Assumes: sec_tick is a one-cycle pulse once per second.
// Notes:   Hours run 0 to 23 inside; the 12-hour view is formed outside.

`timescale 1ns/100ps
`default_nettype none

module rtc_time_counter
   import rtc_pkg::*;
(
   input  wire logic         clk,
   input  wire logic         rst,
   input  wire logic         sec_tick,
   input  wire logic         load_ms,
   input  wire logic         load_h,
   input  wire clock_time_t  load_val,
   output clock_time_t       time_q,
   output logic [NUM_TEV-1:0] ev_q
);

   logic sec_wrap;
   logic min_wrap;
   logic hour_wrap;
   logic sec_ten;
   logic min_ten;
   logic half_day;
   clock_time_t time_next;

   // Carry chain and event terms
   assign sec_wrap  = sec_tick & (time_q.sec == SEC_MAX);
   assign min_wrap  = sec_wrap & (time_q.min == MIN_MAX);
   assign hour_wrap = min_wrap & (time_q.hour == HOUR_MAX);
   assign sec_ten   = sec_tick & (4'(time_q.sec % 6'd10) == DIGIT_LAST);
   assign min_ten   = sec_wrap & (4'(time_q.min % 6'd10) == DIGIT_LAST);
   assign half_day  = min_wrap & (time_q.hour == HOUR_NOON - 5'h01);

   // Next count; a software load overrides counting
   always_comb begin
      time_next = time_q;
      if (sec_tick) begin
         time_next.sec = sec_wrap ? '0 : time_q.sec + 6'h01;
         if (sec_wrap) begin
            time_next.min = min_wrap ? '0 : time_q.min + 6'h01;
         end
         if (min_wrap) begin
            time_next.hour = hour_wrap ? '0 : time_q.hour + 5'h01;
         end
      end
      if (load_ms) begin
         time_next.sec = load_val.sec;
         time_next.min = load_val.min;
      end
      if (load_h) begin
         time_next.hour = load_val.hour;
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         time_q <= TIME_RESET;
         ev_q   <= '0;
      end else begin
         time_q <= time_next;
         ev_q   <= {hour_wrap, half_day | hour_wrap, min_wrap, min_ten,
                    sec_wrap, sec_ten};
      end
   end

endmodule : rtc_time_counter

`default_nettype wire

// ---- verif/ls_osc_model.sv ----
// Purpose: Low-speed oscillator model feeding the real-time clock block.
// Assumes: Runs from the bench clock, HALF bench cycles per level.
// Notes:   hold freezes the level, so a tick can be delayed on purpose.
`timescale 1ns/100ps
`default_nettype none
module ls_osc_model #(
   parameter int HALF = 2
) (
   input  wire logic clk,
   input  wire logic hold,
   output var logic  ls_clk
);
   int cnt = 0;
   initial ls_clk = 1'b0;
   // Toggle every HALF cycles; levels stay long enough to be sampled
   always @(posedge clk) begin
      if (!hold) begin
         if (cnt == HALF - 1) begin
            cnt    <= 0;
            ls_clk <= ~ls_clk;
         end else begin
            cnt <= cnt + 1;
         end
      end
   end
endmodule : ls_osc_model
`default_nettype wire

// ---- verif/rtc_run_control_props.sv ----
// Purpose: Port-level properties of the RTC run control block.
// Assumes: Zero-wait APB, read data registered at the setup edge.
// Notes:   Bound to every instance of the top module.
`timescale 1ns/100ps
`default_nettype none
module rtc_run_control_props
   import rtc_pkg::*;
(
   input wire logic              REF_CLK,
   input wire logic              RST,
   input wire logic              PSEL,
   input wire logic              PENABLE,
   input wire logic              PWRITE,
   input wire logic [ADDR_W-1:0] PADDR,
   input wire logic [DATA_W-1:0] PWDATA,
   input wire logic [DATA_W-1:0] PRDATA,
   input wire logic              PREADY,
   input wire logic              PSLVERR,
   input wire logic              LS_CLK,
   input wire logic              IRQ,
   input wire logic              RTC_CLK_GATE_EN,
   input wire logic              LS_OSC_KEEP_ALIVE
);
   default clocking cb @(posedge REF_CLK); endclocking
   default disable iff (RST);
   ////////////////////////////////////////////////////////////////////////
   // Decoded bus events
   wire logic wr_done = PSEL & PENABLE & PWRITE & PREADY;
   wire logic wr_ctl  = wr_done & (PADDR == ADDR_CTL);
   wire logic wr_ien0 = wr_done & (PADDR == ADDR_IEN) & (PWDATA[9:0] == 0);
   wire logic setup   = PSEL & ~PENABLE & ~PWRITE;
   a_gate_follows_run: assert property (
      wr_ctl |=> RTC_CLK_GATE_EN == $past(PWDATA[CTL_RUN_BIT]))
      else $error("clock gate does not follow run write");
   a_gate_holds: assert property (
      !wr_ctl |=> $stable(RTC_CLK_GATE_EN))
      else $error("clock gate moved without a control write");
   a_osc_alive: assert property (
      LS_OSC_KEEP_ALIVE == RTC_CLK_GATE_EN)
      else $error("oscillator keep-alive differs from run");
   a_irq_masked: assert property (
      wr_ien0 |=> ##1 !IRQ)
      else $error("interrupt with all causes disabled");
   a_run_readback: assert property (
      setup && PADDR == ADDR_CTL |=> PRDATA[0] == $past(RTC_CLK_GATE_EN))
      else $error("run bit reads wrong");
   a_ctl_reserved: assert property (
      setup && PADDR == ADDR_CTL
      |=> PRDATA[31:9] == 0 && PRDATA[7:6] == 0 && PRDATA[3:1] == 0)
      else $error("control reserved bits not zero");
   a_ien_reserved: assert property (
      setup && PADDR == ADDR_IEN |=> PRDATA[31:10] == 0)
      else $error("enable reserved bits not zero");
   a_flag_reserved: assert property (
      setup && PADDR == ADDR_IFLG |=> PRDATA[31:10] == 0)
      else $error("flag reserved bits not zero");
endmodule : rtc_run_control_props
bind rtc_run_control rtc_run_control_props u_props (
   .REF_CLK(REF_CLK), .RST(RST), .PSEL(PSEL), .PENABLE(PENABLE),
   .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA),
   .PREADY(PREADY), .PSLVERR(PSLVERR), .LS_CLK(LS_CLK), .IRQ(IRQ),
   .RTC_CLK_GATE_EN(RTC_CLK_GATE_EN),
   .LS_OSC_KEEP_ALIVE(LS_OSC_KEEP_ALIVE));
`default_nettype wire

// ---- verif/rtc_run_control_tb.sv ----
// Purpose: Self-checking bench for the RTC run control block.
// Assumes: Zero-wait APB slave; low-speed clock from the oscillator model.
// Notes:   Only the 32 Hz cause fires; slower ones need far longer runs.
`timescale 1ns/100ps
`default_nettype none
module rtc_run_control_tb;
   import rtc_pkg::*;
   logic              REF_CLK = 1'b0;
   logic              RST = 1'b1;
   logic              PSEL = 1'b0;
   logic              PENABLE = 1'b0;
   logic              PWRITE = 1'b0;
   logic [ADDR_W-1:0] PADDR = '0;
   logic [DATA_W-1:0] PWDATA = '0;
   logic [DATA_W-1:0] PRDATA;
   logic              PREADY, PSLVERR, LS_CLK, IRQ, GATE, ALIVE;
   logic              ls_hold = 1'b0;
   logic              last_err;
   logic [31:0]       rd;
   logic [31:0]       wv;
   int                fail_count = 0;
   int                num_checks = 0;
   int                seed = 32'h4DED5DA3;
   int                n;
   int                hrs[3] = '{0, 12, 17};
   initial forever #50 REF_CLK = ~REF_CLK;
   rtc_run_control dut (.REF_CLK(REF_CLK), .RST(RST), .PSEL(PSEL),
      .PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA),
      .PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR), .LS_CLK(LS_CLK),
      .IRQ(IRQ), .RTC_CLK_GATE_EN(GATE), .LS_OSC_KEEP_ALIVE(ALIVE));
   ls_osc_model #(.HALF(2)) osc (.clk(REF_CLK), .hold(ls_hold),
      .ls_clk(LS_CLK));
   ////////////////////////////////////////////////////////////////////////
   task automatic report_and_stop;
      $display("checks %0d mismatches %0d", num_checks, fail_count);
      if (fail_count == 0 && num_checks > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask : report_and_stop
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      num_checks++;
      if (got !== exp) begin
         fail_count++;
         $display("ERROR %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk
   // One APB transfer; a leading edge keeps drives from colliding
   task automatic apb(input logic wr, input logic [ADDR_W-1:0] a,
                      input logic [31:0] d);
      @(posedge REF_CLK);
      PSEL    <= 1'b1;
      PENABLE <= 1'b0;
      PWRITE  <= wr;
      PADDR   <= a;
      PWDATA  <= d;
      @(posedge REF_CLK);
      PENABLE <= 1'b1;
      n = 0;
      do begin
         @(posedge REF_CLK);
         n++;
      end while (PREADY !== 1'b1 && n < 16);
      rd = PRDATA;
      last_err = PSLVERR;
      PSEL    <= 1'b0;
      PENABLE <= 1'b0;
      if (PREADY !== 1'b1) begin
         chk(PREADY, 1);
         report_and_stop();
      end
   endtask : apb
   task automatic wait_irq(input logic lvl, input int lim);
      n = 0;
      while (IRQ !== lvl && n < lim) begin
         @(posedge REF_CLK);
         n++;
      end
      chk(IRQ, lvl);
      if (IRQ !== lvl) report_and_stop();
   endtask : wait_irq
   // Status lags the run bit by a tick, so poll with a bound
   task automatic poll_ctl(input logic [31:0] exp);
      for (int k = 0; k < 64 && rd !== exp; k++) apb(0, ADDR_CTL, 0);
      chk(rd, exp);
      if (rd !== exp) report_and_stop();
   endtask : poll_ctl
   // Hour register view: 12-hour folds to 12,1..11; BCD packs digits
   function automatic logic [31:0] hour_view(input int md, input int h);
      int v;
      v = md[0] ? h : ((h % 12 == 0) ? 12 : h % 12);
      if (md[1]) v = (v / 10) * 16 + v % 10;
      return 32'(v) | ((h >= 12) ? 32'h80 : 32'h0);
   endfunction : hour_view
   ////////////////////////////////////////////////////////////////////////
   initial begin
      repeat (5) @(posedge REF_CLK);
      RST <= 1'b0;
      apb(0, ADDR_CTL, 0);
      chk(rd, 0);
      apb(0, ADDR_IFLG, 0);
      chk(rd, 0);
      apb(0, ADDR_CTL + 20'h4, 0);
      chk({rd[30:0], last_err}, 1);
      for (int i = 0; i < 6; i++) begin
         wv = (i == 0) ? 32'hFFFFFFFF : $random(seed);
         apb(1, ADDR_IEN, wv);
         apb(0, ADDR_IEN, 0);
         chk(rd, wv & 32'h3FF);
      end
      foreach (hrs[j]) begin
         apb(1, ADDR_CTL, 32'h10);
         apb(1, ADDR_H, hrs[j]);
         for (int i = 0; i < 4; i++) begin
            apb(1, ADDR_CTL, i << 4);
            apb(0, ADDR_CTL, 0);
            chk(rd, i << 4);
            apb(0, ADDR_H, 0);
            chk(rd, hour_view(i, hrs[j]));
         end
      end
      apb(1, ADDR_MS, 32'h5937);
      apb(0, ADDR_MS, 0);
      chk(rd, 32'h5937);
      apb(1, ADDR_CTL, 32'h0);
      apb(0, ADDR_MS, 0);
      chk(rd, 32'h3B25);
      ls_hold <= 1'b1;
      apb(1, ADDR_CTL, 32'h1);
      apb(0, ADDR_CTL, 0);
      chk(rd, 32'h1);
      chk({GATE, ALIVE}, 3);
      ls_hold <= 1'b0;
      poll_ctl(32'h101);
      ls_hold <= 1'b1;
      apb(1, ADDR_CTL, 32'h0);
      apb(0, ADDR_CTL, 0);
      chk(rd, 32'h100);
      chk({GATE, ALIVE}, 0);
      ls_hold <= 1'b0;
      poll_ctl(32'h0);
      apb(1, ADDR_CTL, 32'h1);
      apb(1, ADDR_IFLG, 32'h3FF);
      apb(1, ADDR_IEN, 32'h1);
      repeat (2000) @(posedge REF_CLK);
      apb(1, ADDR_CTL, 32'h1);
      wait_irq(1'b1, 6000);
      chk(n >= 4000 && n <= 4200, 1);
      apb(0, ADDR_IFLG, 0);
      chk(rd, 32'h1);
      apb(1, ADDR_IEN, 32'h0);
      wait_irq(1'b0, 4);
      apb(1, ADDR_IEN, 32'h1);
      wait_irq(1'b1, 4);
      apb(1, ADDR_IFLG, 32'h0);
      apb(0, ADDR_IFLG, 0);
      chk(rd, 32'h1);
      apb(1, ADDR_IFLG, 32'h1);
      wait_irq(1'b0, 4);
      report_and_stop();
   end
endmodule : rtc_run_control_tb
`default_nettype wire
